// ==== hw/scan_pkg.sv ====
/*
  Shared constants for the boundary-scan test logic: controller states,
  instruction codes, register widths and reset values.
  Assumes a plain SystemVerilog compile with this package compiled first.
*/
package scan_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int IR_WIDTH   = 4;  // Instruction register length.
  localparam int ID_WIDTH   = 32; // Identification register length.
  localparam int NUM_PINS   = 4;  // User pins with a three-cell boundary element.
  localparam int CELLS      = 3;  // Cells per user pin.
  localparam int CELL_INPUT = 0;  // Position of the input capture cell in an element.
  localparam int CELL_OE    = 1;  // Position of the output-enable cell.
  localparam int CELL_OUT   = 2;  // Position of the output-data cell.

  // ----------------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] INS_EXTEST   = 4'h0;
  localparam logic [3:0] INS_SAMPLE   = 4'h1;
  localparam logic [3:0] INS_IDCODE   = 4'h6;
  localparam logic [3:0] INS_USERCODE = 4'h7;
  localparam logic [3:0] INS_CLAMP    = 4'ha;
  localparam logic [3:0] INS_HIGHZ    = 4'hb;
  localparam logic [3:0] INS_IO_SETUP = 4'hd;
  localparam logic [3:0] INS_RECONFIG = 4'he;
  localparam logic [3:0] INS_BYPASS   = 4'hf;

  // Value loaded into the instruction shifter at capture: lsb first gives 1 then 0.
  localparam logic [3:0] IR_CAPTURE_VALUE = 4'h1;

  // Identification word; the value is arbitrary, bit 0 is set as usual.
  localparam logic [31:0] ID_WORD          = 32'h0000_1001;
  // Signature shown before configuration ends; the value is arbitrary.
  localparam logic [31:0] USER_SIG_DEFAULT = 32'hffff_ffff;

  // ----------------------------------------------------------------------
  // Test access controller states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET      = 4'b0000,
    ST_IDLE       = 4'b0001,
    ST_SEL_DR     = 4'b0010,
    ST_CAPTURE_DR = 4'b0011,
    ST_SHIFT_DR   = 4'b0100,
    ST_EXIT1_DR   = 4'b0101,
    ST_PAUSE_DR   = 4'b0110,
    ST_EXIT2_DR   = 4'b0111,
    ST_UPDATE_DR  = 4'b1000,
    ST_SEL_IR     = 4'b1001,
    ST_CAPTURE_IR = 4'b1010,
    ST_SHIFT_IR   = 4'b1011,
    ST_EXIT1_IR   = 4'b1100,
    ST_PAUSE_IR   = 4'b1101,
    ST_EXIT2_IR   = 4'b1110,
    ST_UPDATE_IR  = 4'b1111
  } tap_state_type;

endpackage

// ==== hw/level_sync.sv ====
/*
  Three-stage level synchroniser for one bit.
  Assumes the input is a slowly changing level; the output follows once
  the second and third stages agree.
*/
`timescale 1ns/1ns
module level_sync #(
  parameter logic RESET_VALUE = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic d,
  output logic      q
);

  // ----------------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------------
  logic s1_q; // First stage, read only by the second.
  logic s2_q; // Second stage.
  logic s3_q; // Third stage.

  // The output moves only when the two settled stages agree, filtering a glitch.
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= RESET_VALUE;
      s2_q <= RESET_VALUE;
      s3_q <= RESET_VALUE;
      q    <= RESET_VALUE;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        q <= s3_q;
      end
    end
  end

endmodule

// ==== hw/boundary_scan.sv ====
/*
  Boundary-scan test logic: test access controller, instruction register,
  bypass, identification and boundary registers, pin multiplexers, and the
  hand-off to the configuration logic.
  Assumes tck is a free clock from the tester, rst is synchronous to clock,
  and config_done comes from configuration logic on clock.
*/
`timescale 1ns/1ns
module boundary_scan (
  input  wire logic                         clock,
  input  wire logic                         rst,
  input  wire logic                         tck,
  input  wire logic                         tms,
  input  wire logic                         tdi,
  output logic                              tdo,
  output logic                              tdo_oe,
  input  wire logic                         reload_request_n,
  input  wire logic                         config_done,
  output logic                              config_halt,
  output logic                              reconfigure_pulse,
  input  wire logic [31:0]                  user_signature,
  input  wire logic [scan_pkg::NUM_PINS-1:0] core_output_value,
  input  wire logic [scan_pkg::NUM_PINS-1:0] core_output_enable_n,
  input  wire logic [scan_pkg::NUM_PINS-1:0] keeper_enable,
  input  wire logic [scan_pkg::NUM_PINS-1:0] pin_in,
  output logic      [scan_pkg::NUM_PINS-1:0] pin_out,
  output logic      [scan_pkg::NUM_PINS-1:0] pin_oe,
  output logic                              scan_active
);

  localparam int N    = scan_pkg::NUM_PINS;
  localparam int BSRW = scan_pkg::NUM_PINS * scan_pkg::CELLS;

  // ----------------------------------------------------------------------
  // Crossings between the system clock and tck
  // ----------------------------------------------------------------------
  logic done_q;         // Configuration finished, on clock.
  logic rst_tck;        // System reset seen on tck.
  logic done_tck;       // Configuration finished, seen on tck.
  logic reload_n_tck;   // Reload pin level, seen on tck.
  logic halt_q;         // Configuration halted by the setup instruction, on tck.
  logic reconf_tgl_q;   // Toggles once per reconfigure instruction, on tck.
  logic halt_clk;       // Halt level seen on clock.
  logic reconf_clk;     // Toggle level seen on clock.
  logic reconf_seen_q;  // Last toggle level taken on clock.

  // Configuration status is registered once on its own clock before crossing.
  always_ff @(posedge clock) begin
    if (rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= config_done;
    end
  end

  level_sync #(.RESET_VALUE(1'b1)) u_rst_sync (
    .clk (tck),
    .rst (1'b0),
    .d   (rst),
    .q   (rst_tck)
  );
  level_sync #(.RESET_VALUE(1'b0)) u_done_sync (
    .clk (tck),
    .rst (rst_tck),
    .d   (done_q),
    .q   (done_tck)
  );
  level_sync #(.RESET_VALUE(1'b1)) u_reload_sync (
    .clk (tck),
    .rst (rst_tck),
    .d   (reload_request_n),
    .q   (reload_n_tck)
  );
  level_sync #(.RESET_VALUE(1'b0)) u_halt_sync (
    .clk (clock),
    .rst (rst),
    .d   (halt_q),
    .q   (halt_clk)
  );
  level_sync #(.RESET_VALUE(1'b0)) u_reconf_sync (
    .clk (clock),
    .rst (rst),
    .d   (reconf_tgl_q),
    .q   (reconf_clk)
  );

  // A toggle, not a pulse, crosses so that a reconfigure cannot be missed
  // when tck runs far slower or faster than clock.
  always_ff @(posedge clock) begin
    if (rst) begin
      reconf_seen_q     <= 1'b0;
      reconfigure_pulse <= 1'b0;
      config_halt       <= 1'b0;
    end else begin
      reconf_seen_q     <= reconf_clk;
      reconfigure_pulse <= reconf_clk ^ reconf_seen_q;
      config_halt       <= halt_clk;
    end
  end

  // ----------------------------------------------------------------------
  // Test access controller
  // ----------------------------------------------------------------------
  scan_pkg::tap_state_type state_q; // Controller state.
  scan_pkg::tap_state_type state_d; // Next controller state.

  // Standard sixteen-state walk, steered by tms on each rising tck.
  always_comb begin
    case (state_q)
      scan_pkg::ST_RESET:      state_d = tms ? scan_pkg::ST_RESET     : scan_pkg::ST_IDLE;
      scan_pkg::ST_IDLE:       state_d = tms ? scan_pkg::ST_SEL_DR    : scan_pkg::ST_IDLE;
      scan_pkg::ST_SEL_DR:     state_d = tms ? scan_pkg::ST_SEL_IR    : scan_pkg::ST_CAPTURE_DR;
      scan_pkg::ST_CAPTURE_DR: state_d = tms ? scan_pkg::ST_EXIT1_DR  : scan_pkg::ST_SHIFT_DR;
      scan_pkg::ST_SHIFT_DR:   state_d = tms ? scan_pkg::ST_EXIT1_DR  : scan_pkg::ST_SHIFT_DR;
      scan_pkg::ST_EXIT1_DR:   state_d = tms ? scan_pkg::ST_UPDATE_DR : scan_pkg::ST_PAUSE_DR;
      scan_pkg::ST_PAUSE_DR:   state_d = tms ? scan_pkg::ST_EXIT2_DR  : scan_pkg::ST_PAUSE_DR;
      scan_pkg::ST_EXIT2_DR:   state_d = tms ? scan_pkg::ST_UPDATE_DR : scan_pkg::ST_SHIFT_DR;
      scan_pkg::ST_UPDATE_DR:  state_d = tms ? scan_pkg::ST_SEL_DR    : scan_pkg::ST_IDLE;
      scan_pkg::ST_SEL_IR:     state_d = tms ? scan_pkg::ST_RESET     : scan_pkg::ST_CAPTURE_IR;
      scan_pkg::ST_CAPTURE_IR: state_d = tms ? scan_pkg::ST_EXIT1_IR  : scan_pkg::ST_SHIFT_IR;
      scan_pkg::ST_SHIFT_IR:   state_d = tms ? scan_pkg::ST_EXIT1_IR  : scan_pkg::ST_SHIFT_IR;
      scan_pkg::ST_EXIT1_IR:   state_d = tms ? scan_pkg::ST_UPDATE_IR : scan_pkg::ST_PAUSE_IR;
      scan_pkg::ST_PAUSE_IR:   state_d = tms ? scan_pkg::ST_EXIT2_IR  : scan_pkg::ST_PAUSE_IR;
      scan_pkg::ST_EXIT2_IR:   state_d = tms ? scan_pkg::ST_UPDATE_IR : scan_pkg::ST_SHIFT_IR;
      scan_pkg::ST_UPDATE_IR:  state_d = tms ? scan_pkg::ST_SEL_DR    : scan_pkg::ST_IDLE;
      default:                 state_d = scan_pkg::ST_RESET;
    endcase
  end

  // Five high tms edges in a row end in reset whatever the start state.
  always_ff @(posedge tck) begin
    if (rst_tck) begin
      state_q <= scan_pkg::ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------------
  logic [3:0] ir_shift_q; // Instruction shifter.
  logic [3:0] ir_q;       // Active instruction.
  wire in_reset    = (state_q == scan_pkg::ST_RESET);
  wire shift_dr    = (state_q == scan_pkg::ST_SHIFT_DR);
  wire shift_ir    = (state_q == scan_pkg::ST_SHIFT_IR);
  wire capture_dr  = (state_q == scan_pkg::ST_CAPTURE_DR);
  wire update_dr   = (state_q == scan_pkg::ST_UPDATE_DR);
  wire update_ir   = (state_q == scan_pkg::ST_UPDATE_IR);
  // Configuration counts as running only while reload is released, not done and not halted.
  wire cfg_busy    = reload_n_tck && !done_tck && !halt_q;
  wire ins_safe    = (ir_q == scan_pkg::INS_BYPASS) || (ir_q == scan_pkg::INS_IDCODE)
                  || (ir_q == scan_pkg::INS_USERCODE) || (ir_q == scan_pkg::INS_SAMPLE)
                  || (ir_q == scan_pkg::INS_IO_SETUP);
  // Unsafe codes during configuration act as bypass; a reconfigure code still toggles the reconfigure request.
  wire [3:0] ir_eff = (cfg_busy && !ins_safe) ? scan_pkg::INS_BYPASS : ir_q;
  wire sel_sample  = (ir_eff == scan_pkg::INS_SAMPLE);
  wire sel_extest  = (ir_eff == scan_pkg::INS_EXTEST);
  wire sel_idcode  = (ir_eff == scan_pkg::INS_IDCODE);
  wire sel_user    = (ir_eff == scan_pkg::INS_USERCODE);
  wire sel_clamp   = (ir_eff == scan_pkg::INS_CLAMP);
  wire sel_highz   = (ir_eff == scan_pkg::INS_HIGHZ);
  // One register per code; every code not named above lands on bypass.
  wire sel_bsr     = sel_sample || sel_extest;
  wire sel_id      = sel_idcode || sel_user;
  wire sel_bypass  = !sel_bsr && !sel_id;

  // Shifter captures 1 then 0 in its two low bits so the tester sees 10 first.
  always_ff @(posedge tck) begin
    if (rst_tck || in_reset) begin
      ir_shift_q <= scan_pkg::IR_CAPTURE_VALUE;
      ir_q       <= scan_pkg::INS_IDCODE;
    end else begin
      if (state_q == scan_pkg::ST_CAPTURE_IR) begin
        ir_shift_q <= scan_pkg::IR_CAPTURE_VALUE;
      end else if (shift_ir) begin
        ir_shift_q <= {tdi, ir_shift_q[3:1]};
      end
      if (update_ir) begin
        ir_q <= ir_shift_q;
      end
    end
  end

  // Halt is set by the setup instruction and cleared by either restart path.
  always_ff @(posedge tck) begin
    if (rst_tck) begin
      halt_q       <= 1'b0;
      reconf_tgl_q <= 1'b0;
    end else begin
      if (update_ir && ir_shift_q == scan_pkg::INS_RECONFIG) begin
        halt_q       <= 1'b0;
        reconf_tgl_q <= ~reconf_tgl_q;
      end else if (update_ir && ir_shift_q == scan_pkg::INS_IO_SETUP) begin
        halt_q <= 1'b1;
      end else if (!reload_n_tck) begin
        halt_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Bypass and identification registers
  // ----------------------------------------------------------------------
  logic        bypass_q; // Single bypass bit.
  logic [31:0] id_q;     // Identification shifter.
  // The user value is trusted only after configuration is seen done.
  wire  [31:0] sig_word = done_tck ? user_signature : scan_pkg::USER_SIG_DEFAULT;

  always_ff @(posedge tck) begin
    if (rst_tck) begin
      bypass_q <= 1'b0;
      id_q     <= scan_pkg::ID_WORD;
    end else begin
      if (capture_dr) begin
        bypass_q <= 1'b0;
      end else if (shift_dr && sel_bypass) begin
        bypass_q <= tdi;
      end
      if (capture_dr && sel_idcode) begin
        id_q <= scan_pkg::ID_WORD;
      end else if (capture_dr && sel_user) begin
        id_q <= sig_word;
      end else if (shift_dr && sel_id) begin
        id_q <= {tdi, id_q[31:1]};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Boundary register and pin multiplexers
  // ----------------------------------------------------------------------
  logic [BSRW-1:0] cap_q;   // Capture cells, also the shift chain.
  logic [BSRW-1:0] upd_q;   // Update cells.
  logic [BSRW-1:0] cap_val; // What each capture cell takes in capture.
  wire  drive_upd = sel_extest || sel_clamp;

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_pin
      localparam int B = gi * scan_pkg::CELLS;
      // Output-enable update cell is active low: 0 drives the data cell.
      wire upd_drive  = !upd_q[B + scan_pkg::CELL_OE];
      // After configuration an enabled keeper wins over the clamp value.
      wire keep_wins  = sel_clamp && done_tck && keeper_enable[gi];
      assign pin_oe[gi]  = sel_highz ? 1'b0
                         : drive_upd ? (upd_drive && !keep_wins)
                         : !core_output_enable_n[gi];
      assign pin_out[gi] = drive_upd ? upd_q[B + scan_pkg::CELL_OUT]
                         : core_output_value[gi];
      // Input cells take the pin; otherwise sample takes the core and external test takes what is on the pin now.
      assign cap_val[B + scan_pkg::CELL_INPUT] = pin_in[gi];
      assign cap_val[B + scan_pkg::CELL_OE]    = sel_extest ? !pin_oe[gi]
                                               : core_output_enable_n[gi];
      assign cap_val[B + scan_pkg::CELL_OUT]   = sel_extest ? pin_out[gi]
                                               : core_output_value[gi];
    end
  endgenerate

  // Pin inputs are sampled straight into capture; a tester must let them
  // settle before capture, as the cells cannot hold a synchroniser each.
  always_ff @(posedge tck) begin
    if (rst_tck || in_reset) begin
      cap_q <= '0;
      upd_q <= '1;
    end else begin
      if (capture_dr && sel_bsr) begin
        cap_q <= cap_val;
      end else if (shift_dr && sel_bsr) begin
        cap_q <= {tdi, cap_q[BSRW-1:1]};
      end
      if (update_dr && sel_bsr) begin
        upd_q <= cap_q;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Serial output on the falling edge
  // ----------------------------------------------------------------------
  wire dr_bit  = sel_bsr ? cap_q[0] : sel_id ? id_q[0] : bypass_q;
  wire out_bit = shift_ir ? ir_shift_q[0] : dr_bit;

  // The enable follows the state one half cycle late, on and off alike.
  always_ff @(negedge tck) begin
    if (rst_tck) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo    <= out_bit;
      tdo_oe <= shift_ir || shift_dr;
    end
  end

  assign scan_active = !in_reset;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_tms_high5;
    tms [*5];
  endsequence
  sequence s_exit_pair;
    (state_q == scan_pkg::ST_SHIFT_DR && tms) ##1 tms;
  endsequence

  chk_tms_forces_reset: assert property (@(posedge tck) disable iff (rst_tck)
    s_tms_high5 |=> state_q == scan_pkg::ST_RESET)
    else $error("five high tms edges did not reach reset");
  chk_shift_holds: assert property (@(posedge tck) disable iff (rst_tck)
    shift_dr && !tms |=> shift_dr)
    else $error("left data shift with tms low");
  chk_exit_to_update: assert property (@(posedge tck) disable iff (rst_tck)
    s_exit_pair |=> update_dr)
    else $error("two high tms from shift did not reach update");
  chk_update_copies: assert property (@(posedge tck) disable iff (rst_tck)
    update_dr && sel_bsr |=> upd_q == $past(cap_q))
    else $error("update cells differ from capture cells");
  chk_ir_first_bits: assert property (@(posedge tck) disable iff (rst_tck)
    state_q == scan_pkg::ST_CAPTURE_IR ##1 shift_ir |-> out_bit && !ir_shift_q[1])
    else $error("instruction capture pattern wrong");
  chk_reset_idcode: assert property (@(posedge tck) disable iff (rst_tck)
    in_reset |=> ir_q == scan_pkg::INS_IDCODE)
    else $error("reset did not select identification");
  chk_bypass_bit: assert property (@(posedge tck) disable iff (rst_tck)
    shift_dr && sel_bypass |=> bypass_q == $past(tdi))
    else $error("bypass bit did not take tdi");
  chk_highz_pins: assert property (@(posedge tck) disable iff (rst_tck)
    sel_highz |-> pin_oe == '0)
    else $error("driver enabled under high impedance");
  chk_extest_drive: assert property (@(posedge tck) disable iff (rst_tck)
    sel_extest |-> pin_out[0] == upd_q[scan_pkg::CELL_OUT]
                   && pin_oe[0] == !upd_q[scan_pkg::CELL_OE])
    else $error("external test not driving from update cells");
  chk_reconf_single: assert property (@(posedge clock) disable iff (rst)
    reconfigure_pulse |=> !reconfigure_pulse)
    else $error("reconfigure pulse longer than one cycle");

endmodule

// ==== bench/tap_tester.sv ====
/*
  Model of the external tester that drives the scan link.
  Assumes the bench calls step once for every link cycle.
*/
`timescale 1ns/1ns
module tap_tester (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  // ------------------------------------------------------------
  // Link clock and serial drive
  // ------------------------------------------------------------
  // Free-running clock at 160 ns; tms idles high so the controller stays in reset.
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    forever #80 tck = ~tck;
  end
  // One link cycle: change after the falling edge and sample at the rising edge.
  // An undriven tdo reads as z, so any bit read outside a shift state mismatches.
  task automatic step(input logic m, input logic d, output logic o);
    @(negedge tck);
    tms <= m;
    tdi <= d;
    @(posedge tck);
    o = tdo_oe ? tdo : 1'bz;
  endtask
endmodule

// ==== bench/boundary_scan_bench.sv ====
/*
  Self-checking bench for the boundary-scan logic.
  Assumes scan_pkg is compiled first and the tester model drives the link.
*/
`timescale 1ns/1ns
module boundary_scan_bench;
  logic        clock, rst, tck, tms, tdi, tdo, tdo_oe, reload_request_n, config_done;
  logic        config_halt, reconfigure_pulse, scan_active;
  logic [31:0] user_signature, d;
  logic [3:0]  core_output_value, core_output_enable_n, keeper_enable, pin_in;
  logic [3:0]  pin_out, pin_oe, cap;
  int          mismatches, cmp_count, pulses;
  // Pins 0 and 1 drive 1 and 0, pins 2 and 3 stay off (enable cells are active low).
  localparam logic [11:0] PRELOAD = 12'h584;
  boundary_scan u_boundary_scan (
    .clock                (clock),
    .rst                  (rst),
    .tck                  (tck),
    .tms                  (tms),
    .tdi                  (tdi),
    .tdo                  (tdo),
    .tdo_oe               (tdo_oe),
    .reload_request_n     (reload_request_n),
    .config_done          (config_done),
    .config_halt          (config_halt),
    .reconfigure_pulse    (reconfigure_pulse),
    .user_signature       (user_signature),
    .core_output_value    (core_output_value),
    .core_output_enable_n (core_output_enable_n),
    .keeper_enable        (keeper_enable),
    .pin_in               (pin_in),
    .pin_out              (pin_out),
    .pin_oe               (pin_oe),
    .scan_active          (scan_active)
  );
  tap_tester u_tap_tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
  // ------------------------------------------------------------
  // Clock, counters and helpers
  // ------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Counts one-clock reconfigure pulses.
  always @(posedge clock) if (reconfigure_pulse === 1'b1) pulses <= pulses + 1;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Expected capture word: input, enable and output cells per pin.
  function automatic logic [11:0] snap();
    logic [11:0] w;
    for (int i = 0; i < 4; i++) w[3*i +: 3] = {core_output_value[i], core_output_enable_n[i], pin_in[i]};
    return w;
  endfunction
  task automatic go_reset();
    logic o;
    for (int k = 0; k < 5; k++) u_tap_tester.step(1'b1, 1'b0, o);
  endtask
  // Reaches the instruction shift with 0,1,1,0,0, shifts the code, updates, ends in run-idle.
  task automatic load_ir(input logic [3:0] code);
    logic       o;
    logic [4:0] walk;
    walk = 5'b00110;
    for (int k = 0; k < 5; k++) u_tap_tester.step(walk[k], 1'b0, o);
    for (int k = 0; k < 4; k++) u_tap_tester.step(k == 3, code[k], cap[k]);
    u_tap_tester.step(1'b1, 1'b0, o);
    // The instruction takes hold on the edge that leaves update; half a cycle
    // more lets the pin multiplexers settle before anyone looks at them.
    u_tap_tester.step(1'b0, 1'b0, o);
    @(negedge tck);
    check(cap[1:0], 2'b01);
  endtask
  // Capture, shift n bits lsb first, then update; ends in run-idle.
  task automatic scan_dr(input int n, input logic [31:0] din);
    logic o;
    d = '0;
    for (int k = 0; k < 4; k++) u_tap_tester.step(k == 1, 1'b0, o);
    for (int k = 0; k < n; k++) u_tap_tester.step(k == n - 1, din[k], d[k]);
    u_tap_tester.step(1'b1, 1'b0, o);
    u_tap_tester.step(1'b0, 1'b0, o);
    check(tdo_oe, 1'b0);
  endtask
  task automatic wait_halt(input logic want);
    for (int n = 0; n < 40 && config_halt !== want; n++) @(posedge clock);
    check(config_halt, want);
  endtask
  // ------------------------------------------------------------
  // Main sequence; reset spans several link cycles so it reaches the link side.
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    reload_request_n = 1'b1;
    config_done = 1'b0;
    user_signature = 32'h1234_5678;
    core_output_value = 4'ha;
    core_output_enable_n = 4'h5;
    keeper_enable = 4'h1;
    pin_in = 4'h6;
    repeat (70) @(posedge clock);
    rst <= 1'b0;
    repeat (70) @(posedge clock);
    go_reset();
    scan_dr(32, '0);
    check(d, scan_pkg::ID_WORD);
    load_ir(scan_pkg::INS_BYPASS);
    scan_dr(4, 32'hb);
    check(d, 32'h6);
    load_ir(scan_pkg::INS_USERCODE);
    scan_dr(32, '0);
    check(d, scan_pkg::USER_SIG_DEFAULT);
    load_ir(scan_pkg::INS_EXTEST);
    check(pin_oe, 4'ha);
    scan_dr(2, 32'h3);
    check(d, 32'h2);
    // With reload held low configuration is not running, so high impedance takes hold.
    @(posedge clock);
    reload_request_n <= 1'b0;
    load_ir(scan_pkg::INS_HIGHZ);
    check(pin_oe, 4'h0);
    @(posedge clock);
    reload_request_n <= 1'b1;
    load_ir(scan_pkg::INS_IO_SETUP);
    wait_halt(1'b1);
    load_ir(scan_pkg::INS_SAMPLE);
    check({pin_out, pin_oe}, 8'haa);
    scan_dr(24, {8'h0, PRELOAD, PRELOAD});
    check(d, {8'h0, PRELOAD, snap()});
    load_ir(scan_pkg::INS_EXTEST);
    check({pin_out[1:0], pin_oe}, 6'h13);
    scan_dr(12, PRELOAD);
    check(d & 32'h249, 32'h048);
    load_ir(scan_pkg::INS_HIGHZ);
    check(pin_oe, 4'h0);
    scan_dr(2, 32'h1);
    check(d, 32'h2);
    load_ir(scan_pkg::INS_CLAMP);
    check(pin_oe, 4'h3);
    load_ir(scan_pkg::INS_RECONFIG);
    wait_halt(1'b0);
    for (int n = 0; n < 40 && pulses == 0; n++) @(posedge clock);
    check(pulses, 1);
    @(posedge clock);
    config_done <= 1'b1;
    load_ir(scan_pkg::INS_CLAMP);
    check(pin_oe, 4'h2);
    load_ir(scan_pkg::INS_USERCODE);
    scan_dr(32, '0);
    check(d, 32'h1234_5678);
    go_reset();
    check({scan_active, pin_oe}, 5'h0a);
    end_of_test();
  end
  // Cuts a hang short.
  initial begin
    repeat (100000) @(posedge clock);
    mismatches++;
    end_of_test();
  end
endmodule
